// file: shared/quad_output_read_pkg.sv
// Shared constants for the quad read link between flash end and host end
package quad_output_read_pkg;
	localparam logic [7:0] OP_QOUT = 8'h6B;
	localparam logic [7:0] OP_QADDR = 8'hEB;
	localparam logic [7:0] OP_QWORD = 8'hE7;
	localparam logic [7:0] OP_SET_WRAP = 8'h77;
	localparam logic [7:0] OP_SET_PARAM = 8'hC0;
	localparam logic [7:0] OP_QPI_ON = 8'h38;
	localparam logic [7:0] OP_QPI_OFF = 8'hFF;
	localparam int ADDR_W = 24;
	// Last rise index of each shift phase, single line and four lines
	localparam logic [5:0] BYTE_LAST_S = 6'h07;
	localparam logic [5:0] BYTE_LAST_Q = 6'h01;
	localparam logic [5:0] ADDR_LAST_S = 6'h17;
	localparam logic [5:0] ADDR_LAST_Q = 6'h05;
	localparam logic [5:0] WRAP_LAST_S = 6'h1F;
	localparam logic [3:0] QOUT_DUMMY = 4'h8;
	localparam logic [3:0] SPI_DUMMY_DC0 = 4'h4;
	localparam logic [3:0] SPI_DUMMY_DC1 = 4'h6;
	localparam logic [3:0] WORD_DUMMY = 4'h2;
	localparam logic [3:0] MODE_CLKS = 4'h2;
	localparam logic [1:0] CONT_KEEP = 2'h2;
	localparam int MODE_SEL_LSB = 4;
	localparam int WRAP_DIS_BIT = 4;
	localparam int WRAP_LEN_LSB = 5;
	localparam int PARAM_DUMMY_LSB = 4;
	localparam int PARAM_WRAP_LSB = 0;
	localparam logic [5:0] DEV_SYNC_INIT = 6'h2F;
	localparam logic [3:0] IO_IDLE = 4'hF;
	// Host register word indices
	localparam logic [2:0] REG_CMD = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_ARG = 3'h2;
	localparam logic [2:0] REG_LEN = 3'h3;
	localparam logic [2:0] REG_STAT = 3'h4;
	localparam logic [2:0] REG_RDATA = 3'h5;
	localparam int CMD_QPI_BIT = 8;
	localparam int CMD_SKIP_BIT = 9;
	localparam int SCLK_HALF_CYC = 8;

	function automatic logic [3:0] param_dummy(input logic [1:0] code);
		case (code)
			2'h0: param_dummy = 4'hA;
			2'h1: param_dummy = 4'h4;
			2'h2: param_dummy = 4'h6;
			default: param_dummy = 4'h8;
		endcase
	endfunction

	// 8, 16, 32 or 64 byte section, as an offset mask
	function automatic logic [7:0] wrap_mask(input logic [1:0] code);
		wrap_mask = (8'h08 << code) - 8'h01;
	endfunction
endpackage

// file: shared/qspi_link_if.sv
// Quad SPI link wires shared by host end and flash end
`timescale 1ns/1ps
`default_nettype none
interface qspi_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] h_out;
	logic [3:0] h_oe;
	logic [3:0] d_out;
	logic [3:0] d_oe;
	logic [3:0] io;

	// Undriven lines float high as through a pull-up
	assign io = (h_oe & h_out) | (~h_oe & d_oe & d_out) | (~h_oe & ~d_oe);

	modport host (output cs_n, output sclk, output h_out, output h_oe, input io);
	modport dev (input cs_n, input sclk, input io, output d_out, output d_oe);
endinterface
`default_nettype wire

// file: hdl/sync2.sv
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_type;
	sync_type r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r_reg <= {INIT, INIT};
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;
endmodule
`default_nettype wire

// file: hdl/qflash_dev.sv
// Flash end of the quad read link: decode, address, wrap and nibble output
`timescale 1ns/1ps
`default_nettype none
module qflash_dev #(
	parameter int AW = quad_output_read_pkg::ADDR_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	qspi_link_if.dev link,
	input wire logic quad_enable_bit,
	input wire logic busy,
	input wire logic dummy_count_config_bit,
	input wire logic [7:0] mem_data,
	output logic [AW-1:0] mem_addr,
	output logic qpi_mode,
	output logic cont_mode
);
	import quad_output_read_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_CMD, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_WRAP, S_PARAM, S_IGN
	} dev_state_type;

	typedef struct packed {
		dev_state_type st;
		logic cs_d;
		logic sclk_d;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic [7:0] op;
		logic four_line;
		logic cont;
		logic wrap_dis;
		logic [1:0] wrap_len;
		logic [1:0] pdum;
		logic [3:0] dlen;
		logic wrap_on;
		logic nib;
		logic [AW-1:0] addr;
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} dev_regs_type;

	dev_regs_type r_reg, r_next;
	logic [5:0] sync_d;
	logic [5:0] sync_q;
	logic cs_s;
	logic sclk_s;
	logic [3:0] io_s;

	assign sync_d = {link.cs_n, link.sclk, link.io};

	// Pins come from the host's clock domain
	sync2 #(.W(6), .INIT(DEV_SYNC_INIT)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(sync_d),
		.q(sync_q)
	);

	assign cs_s = sync_q[5];
	assign sclk_s = sync_q[4];
	assign io_s = sync_q[3:0];

	always_comb begin
		logic [31:0] sh_in;
		logic quad_in;
		logic [5:0] last;
		logic done;
		logic rise;
		logic fall;
		logic [7:0] byte_in;
		logic [AW-1:0] inc;
		logic [AW-1:0] msk;
		logic [AW-1:0] nxt;
		sh_in = '0;
		quad_in = 1'b0;
		last = '1;
		done = 1'b0;
		rise = sclk_s & ~r_reg.sclk_d;
		fall = ~sclk_s & r_reg.sclk_d;
		byte_in = '0;
		inc = r_reg.addr + AW'(1);
		msk = AW'(wrap_mask(r_reg.wrap_len));
		nxt = '0;
		r_next = r_reg;
		r_next.cs_d = cs_s;
		r_next.sclk_d = sclk_s;

		case (r_reg.st)
			S_CMD: quad_in = r_reg.four_line;
			S_ADDR: quad_in = r_reg.four_line || (r_reg.op != OP_QOUT);
			S_WRAP: quad_in = 1'b0;
			default: quad_in = 1'b1;
		endcase
		case (r_reg.st)
			S_CMD: last = r_reg.four_line ? BYTE_LAST_Q : BYTE_LAST_S;
			S_ADDR: last = quad_in ? ADDR_LAST_Q : ADDR_LAST_S;
			S_MODE, S_PARAM: last = BYTE_LAST_Q;
			S_WRAP: last = WRAP_LAST_S;
			S_DUMMY: last = {2'h0, r_reg.dlen} - 6'h01;
			default: last = '1;
		endcase
		sh_in = quad_in ? {r_reg.sh[27:0], io_s} : {r_reg.sh[30:0], io_s[0]};
		byte_in = sh_in[7:0];
		done = (r_reg.cnt == last);
		// wrap keeps the upper address bits, so output stays in the section
		nxt = r_reg.wrap_on ? ((r_reg.addr & ~msk) | (inc & msk)) : inc;

		if (cs_s) begin
			r_next.st = S_IDLE;
			r_next.io_oe = '0;
			r_next.cnt = '0;
		end else if (r_reg.cs_d) begin
			r_next.cnt = '0;
			r_next.nib = 1'b0;
			// continuous mode resumes at the address
			if (r_reg.cont) begin
				r_next.st = busy ? S_IGN : S_ADDR;
			end else begin
				r_next.st = S_CMD;
			end
		end else if (rise) begin
			r_next.sh = sh_in;
			r_next.cnt = r_reg.cnt + 6'h01;
			case (r_reg.st)
				S_CMD: begin
					if (done) begin
						r_next.cnt = '0;
						r_next.op = byte_in;
						r_next.st = S_IGN;
						case (byte_in)
							OP_QOUT: begin
								if (quad_enable_bit && !busy && !r_reg.four_line) begin
									r_next.st = S_ADDR;
								end
							end
							OP_QADDR, OP_QWORD: begin
								if (quad_enable_bit && !busy) begin
									r_next.st = S_ADDR;
								end
							end
							OP_SET_WRAP: begin
								if (!r_reg.four_line) begin
									r_next.st = S_WRAP;
								end
							end
							OP_SET_PARAM: begin
								if (r_reg.four_line) begin
									r_next.st = S_PARAM;
								end
							end
							OP_QPI_ON: begin
								if (quad_enable_bit) begin
									r_next.four_line = 1'b1;
								end
							end
							OP_QPI_OFF: begin
								r_next.four_line = 1'b0;
								r_next.cont = 1'b0;
							end
							default: r_next.st = S_IGN;
						endcase
					end
				end
				S_ADDR: begin
					if (done) begin
						r_next.cnt = '0;
						r_next.addr = sh_in[AW-1:0];
						// wrap only for four-wire reads in standard mode
						r_next.wrap_on = !r_reg.four_line && !r_reg.wrap_dis && r_reg.op != OP_QOUT;
						if (r_reg.op == OP_QOUT) begin
							r_next.dlen = QOUT_DUMMY;
							r_next.st = S_DUMMY;
						end else begin
							r_next.st = S_MODE;
						end
					end
				end
				S_MODE: begin
					if (done) begin
						r_next.cnt = '0;
						r_next.st = S_DUMMY;
						// any code but 1,0 ends continuous mode
						r_next.cont = byte_in[MODE_SEL_LSB+:2] == CONT_KEEP;
						if (r_reg.op == OP_QWORD) begin
							r_next.dlen = WORD_DUMMY;
						end else if (r_reg.four_line) begin
							r_next.dlen = param_dummy(r_reg.pdum) - MODE_CLKS;
						end else begin
							r_next.dlen = dummy_count_config_bit ? SPI_DUMMY_DC1 : SPI_DUMMY_DC0;
						end
						// Odd word address refused after the mode byte, so all-ones still clears
						if (r_reg.op == OP_QWORD && r_reg.addr[0]) begin
							r_next.st = S_IGN;
						end
					end
				end
				S_DUMMY: begin
					if (done) begin
						r_next.cnt = '0;
						r_next.st = S_DATA;
					end
				end
				S_WRAP: begin
					if (done) begin
						r_next.cnt = '0;
						r_next.wrap_dis = byte_in[WRAP_DIS_BIT];
						r_next.wrap_len = byte_in[WRAP_LEN_LSB+:2];
						r_next.st = S_IGN;
					end
				end
				S_PARAM: begin
					if (done) begin
						r_next.cnt = '0;
						r_next.pdum = byte_in[PARAM_DUMMY_LSB+:2];
						r_next.wrap_len = byte_in[PARAM_WRAP_LSB+:2];
						r_next.st = S_IGN;
					end
				end
				default: r_next.cnt = '0;
			endcase
		end else if (fall && r_reg.st == S_DATA) begin
			// High nibble first, address moves after the low nibble
			r_next.io_oe = IO_IDLE;
			r_next.io_out = r_reg.nib ? mem_data[3:0] : mem_data[7:4];
			r_next.nib = ~r_reg.nib;
			if (r_reg.nib) begin
				r_next.addr = nxt;
			end
		end
	end

	// Mode switches never touch wrap or dummy settings
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.cs_d <= 1'b1;
			r_reg.wrap_dis <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.d_out = r_reg.io_out;
	assign link.d_oe = r_reg.io_oe;
	assign mem_addr = r_reg.addr;
	assign qpi_mode = r_reg.four_line;
	assign cont_mode = r_reg.cont;
endmodule
`default_nettype wire

// file: hdl/qspi_host.sv
// Host end of the quad read link with an Avalon-MM register port
`timescale 1ns/1ps
`default_nettype none
module qspi_host #(
	parameter int SCLK_HALF = quad_output_read_pkg::SCLK_HALF_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	qspi_link_if.host link,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import quad_output_read_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_SEL, H_OP, H_ADR, H_ARG, H_DUM, H_DAT, H_END} host_state_type;

	typedef struct packed {
		host_state_type st;
		logic [7:0] div;
		logic sclk;
		logic cs_n;
		logic [31:0] tx;
		logic [8:0] cnt;
		logic [3:0] io_out;
		logic [3:0] io_oe;
		logic [9:0] cmd;
		logic [23:0] addr;
		logic [11:0] arg;
		logic [7:0] len;
		logic [31:0] rdata;
		logic waitreq;
		logic [31:0] rd;
	} host_regs_type;

	host_regs_type r_reg, r_next;
	logic [3:0] io_s;
	logic [7:0] op;
	logic is_read;
	logic has_addr;
	logic has_arg;
	logic has_dum;

	sync2 #(.W(4), .INIT(IO_IDLE)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(link.io),
		.q(io_s)
	);

	assign op = r_reg.cmd[7:0];
	assign is_read = op == OP_QOUT || op == OP_QADDR || op == OP_QWORD;
	assign has_addr = is_read || op == OP_SET_WRAP;
	assign has_arg = op == OP_QADDR || op == OP_QWORD || op == OP_SET_WRAP || op == OP_SET_PARAM;
	assign has_dum = r_reg.arg[11:8] != 4'h0;

	function automatic logic wide(input host_state_type s, input logic [9:0] c);
		case (s)
			H_OP: wide = c[CMD_QPI_BIT];
			H_ADR: wide = c[CMD_QPI_BIT] || c[7:0] == OP_QADDR || c[7:0] == OP_QWORD;
			H_ARG: wide = c[CMD_QPI_BIT] || c[7:0] != OP_SET_WRAP;
			default: wide = 1'b1;
		endcase
	endfunction

	always_comb begin
		logic tick;
		logic pres;
		logic w;
		logic [8:0] last;
		host_state_type nx;
		tick = r_reg.st != H_IDLE && r_reg.div == 8'(SCLK_HALF - 1);
		pres = 1'b0;
		w = wide(r_reg.st, r_reg.cmd);
		last = '1;
		nx = H_END;
		r_next = r_reg;
		r_next.div = (tick || r_reg.st == H_IDLE) ? 8'h00 : r_reg.div + 8'h01;

		case (r_reg.st)
			H_OP, H_ARG: last = {3'h0, w ? BYTE_LAST_Q : BYTE_LAST_S};
			H_ADR: last = {3'h0, w ? ADDR_LAST_Q : ADDR_LAST_S};
			H_DUM: last = {5'h00, r_reg.arg[11:8]} - 9'h001;
			H_DAT: last = {r_reg.len, 1'b0} - 9'h001;
			default: last = '1;
		endcase
		case (r_reg.st)
			// Parameter command has no address but still carries its byte
			H_OP: nx = has_addr ? H_ADR : (has_arg ? H_ARG : H_END);
			H_ADR: nx = has_arg ? H_ARG : (has_dum ? H_DUM : H_DAT);
			H_ARG: nx = !is_read ? H_END : (has_dum ? H_DUM : H_DAT);
			H_DUM: nx = H_DAT;
			default: nx = H_END;
		endcase

		if (tick) begin
			case (r_reg.st)
				H_SEL: begin
					// Continuous mode starts straight at the address
					r_next.st = r_reg.cmd[CMD_SKIP_BIT] ? H_ADR : H_OP;
					pres = 1'b1;
				end
				H_END: begin
					if (r_reg.sclk) begin
						r_next.sclk = 1'b0;
						r_next.io_oe = '0;
					end else begin
						r_next.cs_n = 1'b1;
						r_next.st = H_IDLE;
					end
				end
				default: begin
					if (!r_reg.sclk) begin
						r_next.sclk = 1'b1;
						r_next.cnt = r_reg.cnt + 9'h001;
						if (r_reg.st == H_DAT) begin
							r_next.rdata = {r_reg.rdata[27:0], io_s};
						end
						if (r_reg.cnt == last) begin
							r_next.cnt = '0;
							r_next.st = nx;
							case (nx)
								H_ADR: r_next.tx = {r_reg.addr, 8'h00};
								H_ARG: r_next.tx = {r_reg.arg[7:0], 24'h000000};
								default: r_next.tx = '0;
							endcase
						end
					end else begin
						r_next.sclk = 1'b0;
						pres = 1'b1;
					end
				end
			endcase
		end

		if (pres) begin
			w = wide(r_next.st, r_reg.cmd);
			r_next.io_out = w ? r_next.tx[31:28] : {3'h0, r_next.tx[31]};
			r_next.tx = w ? {r_next.tx[27:0], 4'h0} : {r_next.tx[30:0], 1'b0};
			case (r_next.st)
				// All four lines driven through the mode byte in wide phases, line 0 alone in single-line phases
				H_OP, H_ADR, H_ARG: r_next.io_oe = w ? IO_IDLE : 4'h1;
				default: r_next.io_oe = '0;
			endcase
		end

		// Avalon slave: one wait cycle, then the access completes
		r_next.waitreq = 1'b1;
		if ((avs_read || avs_write) && r_reg.waitreq) begin
			r_next.waitreq = 1'b0;
			case (avs_address)
				REG_CMD: r_next.rd = {22'h000000, r_reg.cmd};
				REG_ADDR: r_next.rd = {8'h00, r_reg.addr};
				REG_ARG: r_next.rd = {20'h00000, r_reg.arg};
				REG_LEN: r_next.rd = {24'h000000, r_reg.len};
				REG_STAT: r_next.rd = {31'h00000000, r_reg.st != H_IDLE};
				REG_RDATA: r_next.rd = r_reg.rdata;
				default: r_next.rd = '0;
			endcase
		end
		// Settings are frozen while a transfer runs
		if (avs_write && !r_reg.waitreq && r_reg.st == H_IDLE) begin
			case (avs_address)
				REG_CMD: begin
					r_next.cmd = avs_writedata[9:0];
					r_next.st = H_SEL;
					r_next.cs_n = 1'b0;
					r_next.sclk = 1'b0;
					r_next.cnt = '0;
					r_next.div = 8'h00;
					r_next.rdata = '0;
					if (avs_writedata[CMD_SKIP_BIT]) begin
						r_next.tx = {r_reg.addr, 8'h00};
					end else begin
						r_next.tx = {avs_writedata[7:0], 24'h000000};
					end
				end
				REG_ADDR: r_next.addr = avs_writedata[23:0];
				REG_ARG: r_next.arg = avs_writedata[11:0];
				REG_LEN: r_next.len = avs_writedata[7:0];
				default: r_next.len = r_reg.len;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.cs_n <= 1'b1;
			r_reg.waitreq <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.cs_n = r_reg.cs_n;
	assign link.sclk = r_reg.sclk;
	assign link.h_out = r_reg.io_out;
	assign link.h_oe = r_reg.io_oe;
	assign avs_readdata = r_reg.rd;
	assign avs_waitrequest = r_reg.waitreq;
endmodule
`default_nettype wire

// file: dv/quad_output_read_props.sv
// Wire-level checks on the quad read link between host end and flash end
`timescale 1ns/1ps
`default_nettype none
module quad_output_read_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] h_out,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_out,
	input wire logic [3:0] d_oe,
	input wire logic [3:0] io
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence high_half;
		sclk [*6];
	endsequence
	sequence frame_gap;
		cs_n [*4];
	endsequence
	sequence no_answer;
		(d_oe == 4'h0) [*8];
	endsequence
	sequence dev_driving_high;
		sclk && $past(sclk) && d_oe == 4'hF && $past(d_oe) == 4'hF;
	endsequence

	no_clash_a: assert property ((h_oe & d_oe) == 4'h0)
		else $error("both ends drive a line");
	idle_clock_a: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	release_a: assert property ($rose(cs_n) |-> ##[0:4] (d_oe == 4'h0))
		else $error("flash holds lines after deselect");
	gap_hold_a: assert property ($rose(cs_n) |-> frame_gap)
		else $error("frame gap too short");
	half_period_a: assert property ($rose(sclk) |-> high_half)
		else $error("serial clock high phase too short");
	host_hold_a: assert property (sclk && $past(sclk) |-> $stable(h_out) && $stable(h_oe))
		else $error("host lines move while clock high");
	dev_hold_a: assert property (dev_driving_high |-> $stable(io))
		else $error("flash data moves while clock high");
	four_wide_a: assert property (d_oe != 4'h0 |-> d_oe == 4'hF && io == d_out)
		else $error("flash output not four lines wide");
	opcode_quiet_a: assert property ($fell(cs_n) |-> no_answer)
		else $error("flash drives during command phase");
	host_width_a: assert property (h_oe inside {4'h0, 4'h1, 4'hF})
		else $error("host enables a partial line set");
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench: host end and flash end joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import quad_output_read_pkg::*;
	localparam logic [23:0] NW = 24'hFFFFFF;
	logic mclk = 1'b0;
	logic rst_n, avs_read, avs_write, quad_enable_bit, busy, dummy_count_config_bit;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, got;
	logic avs_waitrequest, qpi_mode, cont_mode;
	logic [23:0] mem_addr;
	logic [7:0] mem_data;
	logic [3:0] dq [4] = '{4'h8, 4'h2, 4'h4, 4'h6};
	int bad_count = 0;
	int cmp_count = 0;

	qspi_link_if link();
	qspi_host #(.SCLK_HALF(6)) u_qspi_host (.mclk(mclk), .rst_n(rst_n), .link(link.host),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	qflash_dev u_qflash_dev (.mclk(mclk), .rst_n(rst_n), .link(link.dev),
		.quad_enable_bit(quad_enable_bit), .busy(busy),
		.dummy_count_config_bit(dummy_count_config_bit), .mem_data(mem_data),
		.mem_addr(mem_addr), .qpi_mode(qpi_mode), .cont_mode(cont_mode));
	quad_output_read_props u_quad_output_read_props (.mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
		.h_out(link.h_out), .h_oe(link.h_oe), .d_out(link.d_out), .d_oe(link.d_oe),
		.io(link.io));

	always #5 mclk = ~mclk;
	// Array content is a simple address pattern
	assign mem_data = mem_addr[7:0] ^ 8'hA5;

	// Four bytes from a, wrapping inside the section given by mask m
	function automatic logic [31:0] w(input logic [23:0] a, input logic [23:0] m);
		logic [23:0] b;
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			b = (a & ~m) | ((a + 24'(i)) & m);
			r[31-8*i -: 8] = b[7:0] ^ 8'hA5;
		end
		return r;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic wr, input logic [2:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		avs_address <= idx;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= wd;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 100) begin
			chk(32'h0, 32'h1);
		end
		@(posedge mclk);
	endtask

	// Writes go in before the command word, which starts the frame
	task automatic xfer(input logic [9:0] cmd, input logic [23:0] a, input logic [11:0] arg,
		input logic [7:0] len);
		logic [31:0] st;
		int n;
		acc(1'b1, REG_ADDR, {8'h00, a}, st);
		acc(1'b1, REG_ARG, {20'h00000, arg}, st);
		acc(1'b1, REG_LEN, {24'h000000, len}, st);
		acc(1'b1, REG_CMD, {22'h000000, cmd}, st);
		n = 0;
		st = 32'h1;
		while (st[0] !== 1'b0 && n < 1000) begin
			acc(1'b0, REG_STAT, 32'h0, st);
			n++;
		end
		if (st[0] !== 1'b0) begin
			chk(32'h0, 32'h1);
		end
		acc(1'b0, REG_RDATA, 32'h0, got);
	endtask

	task automatic run(input logic [9:0] cmd, input logic [23:0] a, input logic [11:0] arg,
		input logic [31:0] exp);
		xfer(cmd, a, arg, 8'h04);
		chk(got, exp);
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#900000;
		bad_count++;
		$display("wrong value at %0t: run hung", $time);
		report_and_stop;
	end

	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		quad_enable_bit = 1'b0;
		busy = 1'b0;
		dummy_count_config_bit = 1'b0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		run({2'b00, OP_QOUT}, 24'h000100, 12'h800, 32'hFFFFFFFF);
		xfer({2'b00, OP_QPI_ON}, 24'h0, 12'h0, 8'h00);
		chk({31'h0, qpi_mode}, 32'h0);
		$display("test gating done");
		quad_enable_bit <= 1'b1;
		run({2'b00, OP_QOUT}, 24'h000100, 12'h800, w(24'h000100, NW));
		run({2'b00, OP_QOUT}, 24'hFFFFFE, 12'h800, w(24'hFFFFFE, NW));
		busy <= 1'b1;
		run({2'b00, OP_QADDR}, 24'h000040, 12'h400, 32'hFFFFFFFF);
		busy <= 1'b0;
		run({2'b00, OP_QADDR}, 24'h000200, 12'h400, w(24'h000200, NW));
		dummy_count_config_bit <= 1'b1;
		run({2'b00, OP_QADDR}, 24'h000210, 12'h600, w(24'h000210, NW));
		dummy_count_config_bit <= 1'b0;
		$display("test plain reads done");
		run({2'b00, OP_QADDR}, 24'h000300, 12'h420, w(24'h000300, NW));
		chk({31'h0, cont_mode}, 32'h1);
		run({2'b10, OP_QADDR}, 24'h000480, 12'h400, w(24'h000480, NW));
		chk({31'h0, cont_mode}, 32'h0);
		run({2'b00, OP_QWORD}, 24'h000500, 12'h220, w(24'h000500, NW));
		run({2'b10, OP_QWORD}, 24'h000602, 12'h220, w(24'h000602, NW));
		xfer({2'b00, OP_QPI_OFF}, 24'h0, 12'h0, 8'h00);
		chk({31'h0, cont_mode}, 32'h0);
		run({2'b00, OP_QWORD}, 24'h000701, 12'h200, 32'hFFFFFFFF);
		$display("test continuous done");
		xfer({2'b00, OP_SET_WRAP}, 24'h0, 12'h000, 8'h00);
		run({2'b00, OP_QADDR}, 24'h000106, 12'h400, w(24'h000106, 24'h7));
		xfer({2'b00, OP_SET_WRAP}, 24'h0, 12'h060, 8'h00);
		run({2'b00, OP_QWORD}, 24'h00013E, 12'h200, w(24'h00013E, 24'h3F));
		xfer({2'b00, OP_SET_WRAP}, 24'h0, 12'h000, 8'h00);
		xfer({2'b00, OP_QPI_ON}, 24'h0, 12'h0, 8'h00);
		chk({31'h0, qpi_mode}, 32'h1);
		run({2'b01, OP_QADDR}, 24'h000106, 12'h800, w(24'h000106, NW));
		for (int c = 0; c < 4; c++) begin
			xfer({2'b01, OP_SET_PARAM}, 24'h0, {6'h00, c[1:0], 2'h0, c[1:0]}, 8'h00);
			run({2'b01, OP_QADDR}, 24'h000800 + 24'(c * 16), {dq[c], 8'h00},
				w(24'h000800 + 24'(c * 16), NW));
		end
		$display("test four-line done");
		xfer({2'b01, OP_QPI_OFF}, 24'h0, 12'h0, 8'h00);
		chk({31'h0, qpi_mode}, 32'h0);
		xfer({2'b00, OP_SET_PARAM}, 24'h0, 12'h010, 8'h00);
		xfer({2'b00, OP_QPI_ON}, 24'h0, 12'h0, 8'h00);
		run({2'b01, OP_QADDR}, 24'h000900, 12'h600, w(24'h000900, NW));
		xfer({2'b01, OP_QPI_OFF}, 24'h0, 12'h0, 8'h00);
		run({2'b00, OP_QADDR}, 24'h00013E, 12'h400, w(24'h00013E, 24'h3F));
		xfer({2'b00, OP_SET_WRAP}, 24'h0, 12'h010, 8'h00);
		run({2'b00, OP_QADDR}, 24'h000106, 12'h400, w(24'h000106, NW));
		$display("test wrap exit done");
		report_and_stop;
	end
endmodule
`default_nettype wire
